// File: reset_source_controller_pkg.sv
/*
 * Shared constants and types of the reset source controller: register
 * indices, cause bit positions, timing figures, fuse and source carriers.
 * Assumes a 10 MHz peripheral clock and a 32-bit AXI4-Lite register bus.
 */
package reset_source_controller_pkg;

	////////////////////////////////////////////////////////////////////
	// register map: index, byte address is four times the index
	localparam logic [5:0] IDX_CAUSE      = 6'h00;
	localparam logic [5:0] IDX_SWREQ      = 6'h01;
	localparam logic [5:0] IDX_KEY        = 6'h02;
	localparam logic [5:0] IDX_IRQ_STATUS = 6'h03;
	localparam logic [5:0] IDX_IRQ_CLEAR  = 6'h04;
	localparam logic [5:0] IDX_IRQ_ENABLE = 6'h05;
	localparam int         ADDR_W         = 8;

	// cause flag positions
	localparam int CAUSE_W = 6;
	localparam int CF_POR  = 0;
	localparam int CF_BOR  = 1;
	localparam int CF_EXT  = 2;
	localparam int CF_WDT  = 3;
	localparam int CF_SW   = 4;
	localparam int CF_DBG  = 5;
	localparam logic [CAUSE_W-1:0] CAUSE_RESET = 6'h01;
	localparam logic [CAUSE_W-1:0] CAUSE_POR_ONLY = 6'h01;

	localparam int SW_REQ_BIT = 0;

	// interrupt status bits
	localparam int IRQ_W      = 2;
	localparam int IRQ_DONE   = 0;
	localparam int IRQ_REJECT = 1;

	// protection unlock window, counted in bus clock cycles
	localparam logic [2:0] UNLOCK_CYCLES = 3'h4;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	////////////////////////////////////////////////////////////////////
	// timing
	localparam int CLK_PERIOD_NS  = 100;
	localparam int RESET_PULSE_NS = 50;
	localparam int PULSE_RAW =
		(RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RESET_PULSE_CYC = (PULSE_RAW < 1) ? 1 : PULSE_RAW;

	////////////////////////////////////////////////////////////////////
	// carriers
	typedef struct packed {
		logic       reset_pin_enable;
		logic       startup_scan_select;
		logic [2:0] startup_time_field;
	} fuse_t;

	typedef struct packed {
		logic poweron;
		logic brownout;
		logic reset_pin_n;
		logic watchdog_timeout;
		logic debug_interface;
	} sources_t;

	typedef enum logic [1:0] {
		ST_RUN,
		ST_PULSE,
		ST_HOLD,
		ST_INIT
	} seq_state_t;

endpackage

// File: reset_source_controller.sv
/*
 * Device reset controller: merges reset sources, sequences the system
 * reset through an initialization phase, records causes, and offers a
 * key-guarded software reset over an AXI4-Lite slave.
 * Assumes all source inputs are synchronous to clk_i and that arst_n_i
 * resets only this controller, never by the system reset it drives.
 */
// Summary of operation
// [RQ1] watchdog time-out raises a system reset
// [RQ2] watchdog or software reset pulse about 50 ns; code rounds up to one 100 ns clock
// [RQ3] writing one to request bit resets system
// [RQ4] software reset starts at once, full sequence
// [RQ5] software request bit always reads zero
// [RQ6] debug reset comes only from external debugger
// [RQ7] fuses reload always; debug logic only supply resets
// [RQ8] reset held while any source stays active
// [RQ9] init phase, supply resets add start-up time
// [RQ10] enabled start-up scan lengthens init phase
// [RQ11] requests honoured in active and sleep modes
// [RQ12] software writes key then protected bits quickly
// [RQ13] unprotected write to guarded register ignored
// [RQ14] one cause flag per reset type
// [RQ15] writing one clears a cause flag
// [RQ16] power-on leaves only power-on flag set
// [RQ17] after power-on other flags blocked until boot
// [RQ18] reset pin acts only when fuse enables it
// [RQ19] simultaneous sources each set their flag
`timescale 1ns/1ps
module reset_source_controller #(
	parameter int INIT_CYCLES     = 16,
	parameter int SUT_STEP_CYCLES = 64,
	parameter int CRC_SCAN_CYCLES = 256,
	parameter int CNT_W           = 16,
	parameter logic [7:0] UNLOCK_KEY = 8'hA5 // arbitrary value
) (
	input  wire logic                                  clk_i,
	input  wire logic                                  arst_n_i,
	input  wire reset_source_controller_pkg::sources_t src_i,
	input  wire reset_source_controller_pkg::fuse_t    fuse_i,
	output logic                                       system_reset_o,
	output logic                                       debug_reset_o,
	output logic                                       fuse_reload_o,
	output logic                                       irq_o,
	input  wire logic [7:0]                            s_axi_awaddr,
	input  wire logic                                  s_axi_awvalid,
	output logic                                       s_axi_awready,
	input  wire logic [31:0]                           s_axi_wdata,
	input  wire logic [3:0]                            s_axi_wstrb,
	input  wire logic                                  s_axi_wvalid,
	output logic                                       s_axi_wready,
	output logic [1:0]                                 s_axi_bresp,
	output logic                                       s_axi_bvalid,
	input  wire logic                                  s_axi_bready,
	input  wire logic [7:0]                            s_axi_araddr,
	input  wire logic                                  s_axi_arvalid,
	output logic                                       s_axi_arready,
	output logic [31:0]                                s_axi_rdata,
	output logic [1:0]                                 s_axi_rresp,
	output logic                                       s_axi_rvalid,
	input  wire logic                                  s_axi_rready
);
	import reset_source_controller_pkg::*;

	localparam int MAX_INIT =
		INIT_CYCLES + 7 * SUT_STEP_CYCLES + CRC_SCAN_CYCLES;

	if (INIT_CYCLES < 1 || SUT_STEP_CYCLES < 0 || CRC_SCAN_CYCLES < 0
		|| CNT_W < 3 || CNT_W > 31 || MAX_INIT >= (1 << CNT_W)) begin : g_bad
		$error("reset_source_controller: parameters out of range");
	end

	seq_state_t          state_reg;
	logic [CNT_W-1:0]    cnt_reg;
	logic                supply_reg;
	logic                por_lock_reg;
	logic [CAUSE_W-1:0]  cause_reg;
	logic [CAUSE_W-1:0]  cause_next;
	logic [2:0]          unlock_reg;
	logic                sw_fire_reg;
	logic                reload_reg;
	logic                boot_done;
	logic [IRQ_W-1:0]    irq_status_reg;
	logic [IRQ_W-1:0]    irq_enable_reg;
	logic [CAUSE_W-1:0]  act;
	logic                any_level;
	logic                any_pulse;
	logic                supply_now;
	logic [CNT_W-1:0]    init_len;

	logic                aw_hold_reg;
	logic [5:0]          aw_idx_reg;
	logic                w_hold_reg;
	logic [7:0]          w_data_reg;
	logic                w_strb_reg;
	logic                wr_fire;
	logic                wr_mapped;
	logic                wr_en;
	logic                bvalid_reg;
	logic [1:0]          bresp_reg;
	logic                rvalid_reg;
	logic [31:0]         rdata_reg;
	logic [1:0]          rresp_reg;
	logic [5:0]          ar_idx;
	logic                reject;
	logic                sw_write;

	////////////////////////////////////////////////////////////////////
	// source merging
	always_comb begin
		act = '0;
		act[CF_POR] = src_i.poweron;
		act[CF_BOR] = src_i.brownout;
		// [RQ18] pin gated by fuse
		act[CF_EXT] = fuse_i.reset_pin_enable & ~src_i.reset_pin_n;
		// [RQ1] watchdog time-out request
		act[CF_WDT] = src_i.watchdog_timeout;
		act[CF_SW]  = sw_fire_reg;
		// [RQ6] debugger-only reset input
		act[CF_DBG] = src_i.debug_interface;
	end

	// [RQ8] level sources keep reset
	assign any_level  = act[CF_POR] | act[CF_BOR] | act[CF_EXT]
		| act[CF_DBG];
	assign any_pulse  = act[CF_WDT] | act[CF_SW];
	assign supply_now = act[CF_POR] | act[CF_BOR];

	// [RQ9] supply resets add start-up
	// [RQ10] start-up scan extends init
	always_comb begin
		init_len = CNT_W'(INIT_CYCLES);
		if (supply_reg | supply_now) begin
			init_len = init_len + CNT_W'(SUT_STEP_CYCLES)
				* CNT_W'(fuse_i.startup_time_field);
		end
		if (fuse_i.startup_scan_select) begin
			init_len = init_len + CNT_W'(CRC_SCAN_CYCLES);
		end
	end

	////////////////////////////////////////////////////////////////////
	// reset sequencer; no sleep gating, the peripheral clock always runs
	// [RQ11] accepted in every mode
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			state_reg <= ST_RUN;
			cnt_reg   <= '0;
		end else begin
			case (state_reg)
				ST_RUN: begin
					if (any_level) begin
						state_reg <= ST_HOLD;
					// [RQ2] short internal pulse
					end else if (any_pulse) begin
						state_reg <= ST_PULSE;
						cnt_reg   <= CNT_W'(RESET_PULSE_CYC);
					end
				end
				ST_PULSE: begin
					if (cnt_reg <= CNT_W'(1)) begin
						state_reg <= ST_HOLD;
					end else begin
						cnt_reg <= cnt_reg - CNT_W'(1);
					end
				end
				ST_HOLD: begin
					if (!any_level) begin
						state_reg <= ST_INIT;
						cnt_reg   <= init_len;
					end
				end
				ST_INIT: begin
					// a new request restarts the whole sequence
					// [RQ4] sequence runs to completion
					if (any_level || any_pulse) begin
						state_reg <= ST_HOLD;
					end else if (cnt_reg <= CNT_W'(1)) begin
						state_reg <= ST_RUN;
					end else begin
						cnt_reg <= cnt_reg - CNT_W'(1);
					end
				end
				default: begin
					state_reg <= ST_RUN;
				end
			endcase
		end
	end

	assign boot_done = (state_reg == ST_INIT) && !any_level
		&& !any_pulse && (cnt_reg <= CNT_W'(1));

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			supply_reg <= 1'b1;
		end else if (supply_now) begin
			supply_reg <= 1'b1;
		end else if (boot_done) begin
			supply_reg <= 1'b0;
		end
	end

	// [RQ7] fuse reload on every reset
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			reload_reg <= 1'b0;
		end else begin
			reload_reg <= (state_reg == ST_HOLD) && !any_level;
		end
	end

	assign system_reset_o = (state_reg != ST_RUN);
	// [RQ7] debug logic reset on supply only
	assign debug_reset_o  = system_reset_o & supply_reg;
	assign fuse_reload_o  = reload_reg;

	////////////////////////////////////////////////////////////////////
	// cause flags
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			por_lock_reg <= 1'b1;
		end else if (act[CF_POR]) begin
			por_lock_reg <= 1'b1;
		end else if (boot_done) begin
			// [RQ17] unblock after full boot
			por_lock_reg <= 1'b0;
		end
	end

	always_comb begin
		cause_next = cause_reg;
		// [RQ15] write one clears
		if (wr_en && aw_idx_reg == IDX_CAUSE) begin
			cause_next = cause_next & ~w_data_reg[CAUSE_W-1:0];
		end
		// [RQ16] power-on keeps only its flag
		if (act[CF_POR]) begin
			cause_next = CAUSE_POR_ONLY;
		// [RQ17] others blocked after power-on
		end else if (!por_lock_reg) begin
			// [RQ14] flag per reset type
			// [RQ19] simultaneous sources all recorded
			cause_next = cause_next | act;
		end
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			cause_reg <= CAUSE_RESET;
		end else begin
			cause_reg <= cause_next;
		end
	end

	////////////////////////////////////////////////////////////////////
	// guarded software reset
	assign sw_write = wr_en && aw_idx_reg == IDX_SWREQ;
	// [RQ13] unguarded write ignored
	assign reject   = sw_write && unlock_reg == 3'h0;

	// [RQ12] key opens a short window
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			unlock_reg <= 3'h0;
		end else if (wr_en && aw_idx_reg == IDX_KEY
			&& w_data_reg == UNLOCK_KEY) begin
			unlock_reg <= UNLOCK_CYCLES;
		end else if (sw_write) begin
			unlock_reg <= 3'h0;
		end else if (unlock_reg != 3'h0) begin
			unlock_reg <= unlock_reg - 3'h1;
		end
	end

	// [RQ3] one to request bit resets
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			sw_fire_reg <= 1'b0;
		end else begin
			sw_fire_reg <= sw_write && !reject
				&& w_data_reg[SW_REQ_BIT];
		end
	end

	////////////////////////////////////////////////////////////////////
	// interrupt status, set wins over clear
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			irq_status_reg <= '0;
		end else begin
			irq_status_reg <= (irq_status_reg
				& ~((wr_en && aw_idx_reg == IDX_IRQ_CLEAR)
					? w_data_reg[IRQ_W-1:0] : '0))
				| {reject, boot_done};
		end
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			irq_enable_reg <= '0;
		end else if (wr_en && aw_idx_reg == IDX_IRQ_ENABLE) begin
			irq_enable_reg <= w_data_reg[IRQ_W-1:0];
		end
	end

	assign irq_o = |(irq_status_reg & irq_enable_reg);

	////////////////////////////////////////////////////////////////////
	// AXI4-Lite write channel
	assign s_axi_awready = !aw_hold_reg && !bvalid_reg;
	assign s_axi_wready  = !w_hold_reg && !bvalid_reg;
	assign wr_fire       = aw_hold_reg && w_hold_reg && !bvalid_reg;
	assign wr_mapped     = aw_idx_reg <= IDX_IRQ_ENABLE;
	assign wr_en         = wr_fire && wr_mapped && w_strb_reg;

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			aw_hold_reg <= 1'b0;
			aw_idx_reg  <= '0;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_hold_reg <= 1'b1;
			aw_idx_reg  <= s_axi_awaddr[ADDR_W-1:2];
		end else if (wr_fire) begin
			aw_hold_reg <= 1'b0;
		end
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			w_hold_reg <= 1'b0;
			w_data_reg <= '0;
			w_strb_reg <= 1'b0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_hold_reg <= 1'b1;
			w_data_reg <= s_axi_wdata[7:0];
			w_strb_reg <= s_axi_wstrb[0];
		end else if (wr_fire) begin
			w_hold_reg <= 1'b0;
		end
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			bvalid_reg <= 1'b0;
			bresp_reg  <= RESP_OKAY;
		end else if (wr_fire) begin
			bvalid_reg <= 1'b1;
			bresp_reg  <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready) begin
			bvalid_reg <= 1'b0;
		end
	end

	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp  = bresp_reg;

	////////////////////////////////////////////////////////////////////
	// AXI4-Lite read channel
	assign s_axi_arready = !rvalid_reg;
	assign ar_idx        = s_axi_araddr[ADDR_W-1:2];

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rvalid_reg <= 1'b0;
			rdata_reg  <= '0;
			rresp_reg  <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			rvalid_reg <= 1'b1;
			rresp_reg  <= RESP_OKAY;
			rdata_reg  <= '0;
			case (ar_idx)
				IDX_CAUSE: begin
					rdata_reg <= 32'(cause_reg);
				end
				IDX_IRQ_STATUS: begin
					rdata_reg <= 32'(irq_status_reg);
				end
				IDX_IRQ_ENABLE: begin
					rdata_reg <= 32'(irq_enable_reg);
				end
				// [RQ5] request bit reads zero
				IDX_SWREQ, IDX_KEY, IDX_IRQ_CLEAR: begin
					rdata_reg <= '0;
				end
				default: begin
					rresp_reg <= RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rready) begin
			rvalid_reg <= 1'b0;
		end
	end

	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rdata  = rdata_reg;
	assign s_axi_rresp  = rresp_reg;

endmodule

// File: reset_source_controller_properties.sv
/*
 * Concurrent checks on the reset source controller ports.
 * Assumes it is bound to every controller instance, one clock domain.
 */
`timescale 1ns/1ps
module reset_source_controller_properties
	import reset_source_controller_pkg::*;
#(
	parameter int INIT_CYCLES = 16
) (
	input wire logic        clk_i,
	input wire logic        arst_n_i,
	input wire sources_t    src_i,
	input wire fuse_t       fuse_i,
	input wire logic        system_reset_o,
	input wire logic        debug_reset_o,
	input wire logic        fuse_reload_o,
	input wire logic        irq_o,
	input wire logic [7:0]  s_axi_araddr,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        s_axi_rvalid
);
	logic [15:0] high_cnt_reg;
	logic [7:0]  rd_addr_reg;

	////////////////////////////////////////////////////////////////////
	// length of the current reset span, and the address being read
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			high_cnt_reg <= 16'h0000;
		end else begin
			high_cnt_reg <= system_reset_o ? high_cnt_reg + 16'h0001 : 16'h0000;
		end
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rd_addr_reg <= 8'h00;
		end else if (s_axi_arvalid && s_axi_arready) begin
			rd_addr_reg <= s_axi_araddr;
		end
	end

	////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!arst_n_i);

	a_pin_holds_reset: assert property (
		fuse_i.reset_pin_enable && !src_i.reset_pin_n |=> system_reset_o)
		else $error("enabled pin low without system reset");
	a_level_src_reset: assert property (
		src_i.poweron || src_i.brownout || src_i.debug_interface
		|=> system_reset_o)
		else $error("level source without system reset");
	a_watchdog_reset: assert property (
		src_i.watchdog_timeout |=> system_reset_o)
		else $error("watchdog time-out without system reset");
	a_debug_in_reset: assert property (
		debug_reset_o |-> system_reset_o)
		else $error("debug reset outside system reset");
	a_reload_single: assert property (
		fuse_reload_o |-> system_reset_o ##1 !fuse_reload_o)
		else $error("fuse reload not a pulse inside reset");
	a_init_min_len: assert property (
		$fell(system_reset_o) |-> high_cnt_reg >= INIT_CYCLES)
		else $error("reset released before init phase ended");
	a_swreq_reads_zero: assert property (
		s_axi_rvalid && rd_addr_reg == {IDX_SWREQ, 2'b00}
		|-> s_axi_rdata == 32'h0000_0000)
		else $error("request register read nonzero");
	a_reset_min_span: assert property (
		$rose(system_reset_o) |-> system_reset_o[*3])
		else $error("reset span too short");

	cover property ($fell(system_reset_o));
	cover property (irq_o);
	cover property (fuse_reload_o);
endmodule

bind reset_source_controller reset_source_controller_properties #(
	.INIT_CYCLES(INIT_CYCLES)
) reset_source_controller_properties_inst (
	.clk_i(clk_i),
	.arst_n_i(arst_n_i),
	.src_i(src_i),
	.fuse_i(fuse_i),
	.system_reset_o(system_reset_o),
	.debug_reset_o(debug_reset_o),
	.fuse_reload_o(fuse_reload_o),
	.irq_o(irq_o),
	.s_axi_araddr(s_axi_araddr),
	.s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready),
	.s_axi_rdata(s_axi_rdata),
	.s_axi_rvalid(s_axi_rvalid)
);

// File: reset_requesters_model.sv
/*
 * Far-side model: supply monitors, reset pin, watchdog and debugger.
 * Assumes its task is called just after a rising clock edge.
 */
`timescale 1ns/1ps
module reset_requesters_model (
	input  wire logic                          clk_i,
	output reset_source_controller_pkg::sources_t src_o
);
	import reset_source_controller_pkg::*;

	// pin rests high on its pull-up, every other request idle
	initial src_o = 5'b00100;

	// external requester only
	// index 2 is the active-low pin, the rest are active high
	task automatic request(input int which, input int cycles);
		src_o[which] <= (which != 2);
		repeat (cycles) @(posedge clk_i);
		src_o[which] <= (which == 2);
	endtask
endmodule

// File: reset_source_controller_tb_top.sv
/*
 * Self-checking bench of the reset source controller.
 * Assumes the package, the design, the checker and the far-side model.
 */
`timescale 1ns/1ps
module reset_source_controller_tb_top;
	import reset_source_controller_pkg::*;
	localparam int S_POR = 4, S_BOR = 3, S_PIN = 2, S_WDT = 1, S_DBG = 0;
	localparam logic [7:0] KEY = 8'hA5; // arbitrary value
	localparam logic [7:0] A_CAUSE = {IDX_CAUSE, 2'b00};
	localparam logic [7:0] A_SWREQ = {IDX_SWREQ, 2'b00};
	localparam logic [7:0] A_KEY   = {IDX_KEY, 2'b00};
	localparam logic [7:0] A_STAT  = {IDX_IRQ_STATUS, 2'b00};
	localparam logic [7:0] A_CLR   = {IDX_IRQ_CLEAR, 2'b00};
	localparam logic [7:0] A_EN    = {IDX_IRQ_ENABLE, 2'b00};

	logic        clk_i = 1'b0, arst_n_i = 1'b0;
	logic        awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
	logic        awready, wready, arready, bvalid, rvalid, sys_rst, dbg_rst, irq;
	logic        bready = 1'b0, rready = 1'b0, reload;
	logic [3:0]  wstrb = 4'hF;
	logic [7:0]  awaddr = 8'h00, araddr = 8'h00, rnd = 8'h53;
	logic [31:0] wdata = 32'h0, rdata;
	logic [1:0]  bresp, rresp;
	sources_t    src;
	fuse_t       fuse = 5'b10011;
	logic [31:0] exp_q[$];
	int          fail_count = 0, samples_checked = 0, len0, len1;

	always #50 clk_i = ~clk_i;

	reset_source_controller #(.INIT_CYCLES(2), .SUT_STEP_CYCLES(4),
		.CRC_SCAN_CYCLES(8), .UNLOCK_KEY(KEY)) reset_source_controller_inst (
		.clk_i(clk_i), .arst_n_i(arst_n_i), .src_i(src), .fuse_i(fuse),
		.system_reset_o(sys_rst), .debug_reset_o(dbg_rst),
		.fuse_reload_o(reload), .irq_o(irq),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready));

	reset_requesters_model reset_requesters_model_inst (
		.clk_i(clk_i), .src_o(src));

	////////////////////////////////////////////////////////////////////
	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("unexpected at %0t: got %h want %h", $time, seen, exp);
		end
	endtask

	task automatic tally_and_finish();
		if (fail_count == 0 && samples_checked > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// bready and rready rise with the request and fall once the answer is
	// taken; one idle edge follows so the next call never reassigns them
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] r);
		exp_q.push_back({30'h0, r});
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk_i);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid);
		bready <= 1'b0;
		@(posedge clk_i);
	endtask

	task automatic rd(input logic [7:0] a, input logic [1:0] r,
		input logic [31:0] e);
		exp_q.push_back({r, e[29:0]});
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clk_i);
			if (arready) arvalid <= 1'b0;
		end while (!rvalid);
		rready <= 1'b0;
		@(posedge clk_i);
	endtask

	task automatic wait_run();
		int n;
		n = 0;
		repeat (2) @(posedge clk_i);
		while (sys_rst !== 1'b0 && n < 600) begin
			@(posedge clk_i);
			n++;
		end
	endtask

	// hold is random, the span is timed from the release
	task automatic timed(input int w, input logic d, output int len);
		int rl;
		rl = 0;
		reset_requesters_model_inst.request(w, 2 + rnd[1:0]);
		rnd = lfsr(rnd);
		check({31'h0, dbg_rst}, {31'h0, d});
		len = 0;
		while (sys_rst === 1'b1 && len < 600) begin
			@(posedge clk_i);
			len++;
			rl += (reload === 1'b1);
		end
		check(rl, 32'd1);
	endtask

	always @(posedge clk_i) begin
		if (rvalid) check({rresp, rdata[29:0]}, exp_q.pop_front());
		if (bvalid) check({30'h0, bresp}, exp_q.pop_front());
	end

	////////////////////////////////////////////////////////////////////
	initial begin
		repeat (2) @(posedge clk_i);
		arst_n_i <= 1'b1;
		@(posedge clk_i);
		reset_requesters_model_inst.request(S_WDT, 1);
		wait_run();
		rd(A_CAUSE, RESP_OKAY, 32'h01);
		timed(S_PIN, 1'b0, len0);
		fuse <= 5'b11011;
		timed(S_PIN, 1'b0, len1);
		check(len1 - len0, 32'd8);
		fuse <= 5'b10011;
		timed(S_BOR, 1'b1, len1);
		check(len1 - len0, 32'd12);
		reset_requesters_model_inst.request(S_WDT, 1);
		wait_run();
		rd(A_CAUSE, RESP_OKAY, 32'h0F);
		wr(A_CAUSE, 32'h0B, RESP_OKAY);
		rd(A_CAUSE, RESP_OKAY, 32'h04);
		wr(A_SWREQ, 32'h01, RESP_OKAY);
		repeat (3) @(posedge clk_i);
		check({31'h0, sys_rst}, 32'h0);
		rd(A_SWREQ, RESP_OKAY, 32'h0);
		rd(A_STAT, RESP_OKAY, 32'h03);
		wr(A_EN, {24'h0, rnd}, RESP_OKAY);
		rd(A_EN, RESP_OKAY, {30'h0, rnd[1:0]});
		// low byte strobe off: the write is answered but changes nothing
		wstrb <= 4'hE;
		wr(A_EN, 32'h02, RESP_OKAY);
		wstrb <= 4'hF;
		rd(A_EN, RESP_OKAY, {30'h0, rnd[1:0]});
		wr(A_EN, 32'h02, RESP_OKAY);
		@(posedge clk_i);
		check({31'h0, irq}, 32'h1);
		wr(A_CLR, 32'h03, RESP_OKAY);
		@(posedge clk_i);
		check({31'h0, irq}, 32'h0);
		rd(A_STAT, RESP_OKAY, 32'h0);
		// key, then the guarded write at once
		wr(A_KEY, {24'h0, KEY}, RESP_OKAY);
		wr(A_SWREQ, 32'h01, RESP_OKAY);
		repeat (2) @(posedge clk_i);
		check({31'h0, sys_rst}, 32'h1);
		wait_run();
		fork
			reset_requesters_model_inst.request(S_DBG, 3);
			reset_requesters_model_inst.request(S_WDT, 1);
		join
		wait_run();
		rd(A_CAUSE, RESP_OKAY, 32'h3C);
		wr(A_CAUSE, 32'h3F, RESP_OKAY);
		fuse <= 5'b00011;
		reset_requesters_model_inst.request(S_PIN, 4);
		check({31'h0, sys_rst}, 32'h0);
		rd(A_CAUSE, RESP_OKAY, 32'h00);
		rd(8'h40, RESP_SLVERR, 32'h0);
		wr(8'h40, 32'h1, RESP_SLVERR);
		fork
			reset_requesters_model_inst.request(S_POR, 3);
			reset_requesters_model_inst.request(S_DBG, 2);
		join
		wait_run();
		rd(A_CAUSE, RESP_OKAY, 32'h01);
		tally_and_finish();
	end

	// a hang ends the run well past the expected few hundred cycles
	initial begin
		#(20000 * 100);
		fail_count++;
		tally_and_finish();
	end
endmodule
